// >>> verilog/jsi_sequencer.v
// Scan chain init sequencer: built-in TAP reset or a custom command string
// Functional notes
// RULE_01 - Successor device count and summed IR length are inputs and pad every scan.
// RULE_02 - Non-target IRs get all ones unless a bypass pattern is enabled for them.
// RULE_03 - A bypass pattern is its binary value shifted LSB first into the non-target IRs.
// RULE_04 - The custom program is a colon separated character stream run in order.
// RULE_05 - IR and DR writes shift byte zero first, least significant bit first.
// RULE_06 - Shift data is two hex digits per byte and the bit count is 1 to 256.
// RULE_07 - A wait command idles the TAP for the given decimal number of microseconds.
// RULE_08 - Test reset and system reset commands set levels that hold until changed.
// RULE_09 - Two run commands pulse TCK n times with TMS held high or held low.
// RULE_10 - A configured custom program replaces the built-in reset sequence.
// RULE_11 - Built-in sequence holds test reset 1 ms, releases it, then 5 TCKs TMS high.
// RULE_12 - After init the target chain must show the configured devices around the core.
// RULE_13 - Predecessor count, IR length and optional bypass pattern are handled likewise.
// RULE_14 - Each command finishes fully before the next and completion is flagged at the end.
`timescale 1ns/1ps
`include "jsi_consts.vh"

module jsi_sequencer #(
	parameter [31:0] US_CYCLES = `JSI_US_CYC
) (
	input wire CLK,
	input wire RESET_N,
	input wire START,
	input wire PROG_EN,
	input wire [7:0] PROG_CHAR,
	input wire PROG_VALID,
	input wire PROG_LAST,
	input wire [5:0] PRED_COUNT,
	input wire [5:0] PRED_IRLEN,
	input wire [31:0] PRED_BYPASS,
	input wire PRED_BYPASS_EN,
	input wire [5:0] SUCC_COUNT,
	input wire [5:0] SUCC_IRLEN,
	input wire [31:0] SUCC_BYPASS,
	input wire SUCC_BYPASS_EN,
	output wire TCK,
	output wire TMS,
	output wire TDI,
	output reg TRST_N,
	output reg SYS_RESET_N,
	output reg PROG_READY,
	output reg BUSY,
	output reg DONE,
	output reg CMD_ERROR
);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_PARSE = 3'h1;
localparam [2:0] S_DISP = 3'h2;
localparam [2:0] S_WAIT = 3'h3;
localparam [2:0] S_RUN = 3'h4;
localparam [2:0] S_SCAN = 3'h5;
localparam [2:0] S_FIN = 3'h6;

reg [2:0] state_ff;
reg [2:0] op_ff;
reg [31:0] num_ff;
reg [255:0] data_ff;
reg in_data_ff;
reg last_ff;
reg builtin_ff;
reg [31:0] wait_ff;
reg [31:0] pre_ff;
reg [31:0] run_ff;
reg run_tms_ff;
reg is_ir_ff;
reg [8:0] nbits_ff;
reg [9:0] pos_ff;
reg go_ff;
reg step_tms_ff;
reg step_tdi_ff;
reg step_busy_ff;
wire step_done;

// ****************************************************************
// Helper decoders
// ****************************************************************
// Bypass bit for a chain segment; DR bypass registers take zeros
function byp_bit;
	input ir;
	input en;
	input [31:0] pat;
	input [5:0] idx;
	begin
		if (!ir)
			byp_bit = 1'b0;
		else if (en && !idx[5])
			byp_bit = pat[idx[4:0]]; // RULE_03
		else
			byp_bit = 1'b1; // RULE_02
	end
endfunction

// Returns {valid, nibble} for a folded hex digit
function [4:0] hex_val;
	input [7:0] c;
	reg [7:0] t;
	begin
		t = 8'h00;
		if (c >= `JSI_CH_0 && c <= `JSI_CH_9) begin
			t = c - `JSI_CH_0;
			hex_val = {1'b1, t[3:0]};
		end else if (c >= `JSI_CH_A && c <= `JSI_CH_F) begin
			t = c - `JSI_HEX_OFS;
			hex_val = {1'b1, t[3:0]};
		end else begin
			hex_val = 5'h00;
		end
	end
endfunction

wire [7:0] lc = PROG_CHAR | `JSI_CH_FOLD;
wire [4:0] hx = hex_val(lc);
wire is_dec = (lc >= `JSI_CH_0) && (lc <= `JSI_CH_9);
wire [31:0] num_x10 = {num_ff[28:0], 3'h0} + {num_ff[30:0], 1'b0};
wire take = (state_ff == S_PARSE) && PROG_READY && PROG_VALID;

// ****************************************************************
// Scan position decode
// ****************************************************************
wire [3:0] hdr_len = is_ir_ff ? `JSI_IR_HDR_LEN : `JSI_DR_HDR_LEN;
wire [3:0] hdr_pat = is_ir_ff ? `JSI_IR_HDR_PAT : `JSI_DR_HDR_PAT;
wire [5:0] s_len = is_ir_ff ? SUCC_IRLEN : SUCC_COUNT; // RULE_01
wire [5:0] p_len = is_ir_ff ? PRED_IRLEN : PRED_COUNT; // RULE_13
wire [9:0] q = pos_ff - {6'h00, hdr_len};
wire [9:0] s_end = {4'h0, s_len};
wire [9:0] d_end = s_end + {1'b0, nbits_ff};
wire [9:0] sh_len = d_end + {4'h0, p_len};
wire [9:0] q_pred = q - d_end;
reg cur_tms;
reg cur_tdi;
reg cur_data;
reg cur_end;

always @* begin
	cur_tms = 1'b0;
	cur_tdi = 1'b0;
	cur_data = 1'b0;
	cur_end = 1'b0;
	if (pos_ff < {6'h00, hdr_len}) begin
		cur_tms = hdr_pat[pos_ff[1:0]];
	end else if (q < sh_len) begin
		cur_tms = (q == sh_len - 10'h001);
		if (q < s_end) begin
			cur_tdi = byp_bit(is_ir_ff, SUCC_BYPASS_EN, SUCC_BYPASS,
				q[5:0]); // RULE_01
		end else if (q < d_end) begin
			cur_tdi = data_ff[0]; // RULE_05
			cur_data = 1'b1;
		end else begin
			cur_tdi = byp_bit(is_ir_ff, PRED_BYPASS_EN, PRED_BYPASS,
				q_pred[5:0]); // RULE_13
		end
	end else if (q == sh_len) begin
		cur_tms = 1'b1;
	end else if (q == sh_len + 10'h001) begin
		// Back to run-test idle so the next command starts from a known state
		cur_tms = 1'b0; // RULE_14
	end else begin
		cur_end = 1'b1;
	end
end

// ****************************************************************
// Sequencer
// ****************************************************************
// Returning to the parser after each command but the last keeps commands strictly serial
task back;
	begin
		if (last_ff) begin
			state_ff <= S_FIN;
		end else begin
			state_ff <= S_PARSE;
			PROG_READY <= 1'b1;
		end
	end
endtask

always @(posedge CLK or negedge RESET_N) begin
	if (!RESET_N) begin
		state_ff <= S_IDLE;
		op_ff <= `JSI_OP_NONE;
		num_ff <= 32'h0000_0000;
		data_ff <= {256{1'b0}};
		in_data_ff <= 1'b0;
		last_ff <= 1'b0;
		builtin_ff <= 1'b0;
		wait_ff <= 32'h0000_0000;
		pre_ff <= 32'h0000_0000;
		run_ff <= 32'h0000_0000;
		run_tms_ff <= 1'b0;
		is_ir_ff <= 1'b0;
		nbits_ff <= 9'h000;
		pos_ff <= 10'h000;
		go_ff <= 1'b0;
		step_tms_ff <= 1'b0;
		step_tdi_ff <= 1'b0;
		step_busy_ff <= 1'b0;
		TRST_N <= 1'b1;
		SYS_RESET_N <= 1'b1;
		PROG_READY <= 1'b0;
		BUSY <= 1'b0;
		DONE <= 1'b0;
		CMD_ERROR <= 1'b0;
	end else begin
		go_ff <= 1'b0;
		DONE <= 1'b0;
		case (state_ff)
		S_IDLE: begin
			if (START) begin
				BUSY <= 1'b1;
				CMD_ERROR <= 1'b0;
				last_ff <= 1'b0;
				op_ff <= `JSI_OP_NONE;
				if (PROG_EN) begin
					builtin_ff <= 1'b0; // RULE_10
					state_ff <= S_PARSE;
					PROG_READY <= 1'b1;
				end else begin
					builtin_ff <= 1'b1;
					TRST_N <= 1'b0; // RULE_11
					wait_ff <= `JSI_TRST_HOLD_US;
					pre_ff <= US_CYCLES - 32'h0000_0001;
					state_ff <= S_WAIT;
				end
			end
		end
		S_PARSE: begin
			if (take) begin
				last_ff <= PROG_LAST;
				if (PROG_LAST || lc == `JSI_CH_SEP) begin
					PROG_READY <= 1'b0; // RULE_04
					state_ff <= S_DISP;
				end
				if (lc == `JSI_CH_SEP || lc == `JSI_CH_SPACE) begin
					// Hex mode ends at the separator, else c or d reads as data
					in_data_ff <= in_data_ff && (lc != `JSI_CH_SEP); // RULE_04
				end else if (in_data_ff && hx[4]) begin
					data_ff <= {data_ff[251:0], hx[3:0]}; // RULE_06
				end else if (is_dec) begin
					num_ff <= num_x10 + {28'h0000000, hx[3:0]};
				end else if (lc == `JSI_CH_EQ) begin
					in_data_ff <= 1'b1;
				end else if (lc == `JSI_CH_H && op_ff == `JSI_OP_CLK) begin
					op_ff <= `JSI_OP_RUN;
					run_tms_ff <= 1'b1;
				end else if (lc == `JSI_CH_L && op_ff == `JSI_OP_CLK) begin
					op_ff <= `JSI_OP_RUN;
					run_tms_ff <= 1'b0;
				end else begin
					num_ff <= 32'h0000_0000;
					data_ff <= {256{1'b0}};
					in_data_ff <= 1'b0;
					case (lc)
					`JSI_CH_I: op_ff <= `JSI_OP_IR;
					`JSI_CH_D: op_ff <= `JSI_OP_DR;
					`JSI_CH_W: op_ff <= `JSI_OP_WAIT;
					`JSI_CH_T: op_ff <= `JSI_OP_TRST;
					`JSI_CH_R: op_ff <= `JSI_OP_SRST;
					`JSI_CH_C: op_ff <= `JSI_OP_CLK;
					default: begin
						op_ff <= `JSI_OP_NONE;
						CMD_ERROR <= 1'b1;
					end
					endcase
				end
			end
		end
		S_DISP: begin
			op_ff <= `JSI_OP_NONE;
			case (op_ff)
			`JSI_OP_WAIT: begin
				wait_ff <= num_ff; // RULE_07
				pre_ff <= US_CYCLES - 32'h0000_0001;
				state_ff <= S_WAIT;
			end
			`JSI_OP_TRST: begin
				TRST_N <= ~num_ff[0]; // RULE_08
				back;
			end
			`JSI_OP_SRST: begin
				SYS_RESET_N <= ~num_ff[0]; // RULE_08
				back;
			end
			`JSI_OP_RUN: begin
				run_ff <= num_ff; // RULE_09
				state_ff <= S_RUN;
			end
			`JSI_OP_IR, `JSI_OP_DR: begin
				if (num_ff == 32'h0000_0000 || num_ff > `JSI_MAX_BITS) begin
					CMD_ERROR <= 1'b1; // RULE_06
					back;
				end else begin
					is_ir_ff <= (op_ff == `JSI_OP_IR);
					nbits_ff <= num_ff[8:0];
					pos_ff <= 10'h000;
					state_ff <= S_SCAN;
				end
			end
			`JSI_OP_CLK: begin
				CMD_ERROR <= 1'b1;
				back;
			end
			default: begin
				back;
			end
			endcase
		end
		S_WAIT: begin
			if (wait_ff == 32'h0000_0000) begin
				if (builtin_ff) begin
					TRST_N <= 1'b1; // RULE_11
					run_ff <= `JSI_RESET_TCKS;
					run_tms_ff <= 1'b1;
					state_ff <= S_RUN;
				end else begin
					back; // RULE_14
				end
			end else if (pre_ff == 32'h0000_0000) begin
				pre_ff <= US_CYCLES - 32'h0000_0001;
				wait_ff <= wait_ff - 32'h0000_0001; // RULE_07
			end else begin
				pre_ff <= pre_ff - 32'h0000_0001;
			end
		end
		S_RUN: begin
			if (step_done) begin
				step_busy_ff <= 1'b0;
				run_ff <= run_ff - 32'h0000_0001;
			end else if (!step_busy_ff) begin
				if (run_ff == 32'h0000_0000) begin
					if (builtin_ff)
						state_ff <= S_FIN;
					else
						back; // RULE_14
				end else begin
					go_ff <= 1'b1;
					step_tms_ff <= run_tms_ff; // RULE_09
					step_tdi_ff <= 1'b0;
					step_busy_ff <= 1'b1;
				end
			end
		end
		S_SCAN: begin
			if (step_done) begin
				step_busy_ff <= 1'b0;
				pos_ff <= pos_ff + 10'h001;
				if (cur_data)
					data_ff <= {1'b0, data_ff[255:1]}; // RULE_05
			end else if (!step_busy_ff) begin
				if (cur_end) begin
					back; // RULE_14
				end else begin
					go_ff <= 1'b1;
					step_tms_ff <= cur_tms;
					step_tdi_ff <= cur_tdi;
					step_busy_ff <= 1'b1;
				end
			end
		end
		S_FIN: begin
			BUSY <= 1'b0;
			DONE <= 1'b1; // RULE_14
			PROG_READY <= 1'b0;
			state_ff <= S_IDLE;
		end
		default: begin
			state_ff <= S_IDLE;
		end
		endcase
	end
end

// ****************************************************************
// TCK cycle generator
// ****************************************************************
// One generator serves runs and scans so pin timing is identical for both
jsi_tck_gen u_tck (
	.clk(CLK),
	.reset_n(RESET_N),
	.go(go_ff),
	.tms_in(step_tms_ff),
	.tdi_in(step_tdi_ff),
	.tck_ff(TCK),
	.tms_ff(TMS),
	.tdi_ff(TDI),
	.done_ff(step_done)
);

endmodule // jsi_sequencer

// >>> common/jsi_consts.vh
// Constants shared by the scan init sequencer and its TCK cycle generator
`ifndef JSI_CONSTS_VH
`define JSI_CONSTS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define JSI_CLK_MHZ 100
`define JSI_TCK_HALF_NS 50
`define JSI_TCK_HALF_CYC ((`JSI_TCK_HALF_NS * `JSI_CLK_MHZ + 999) / 1000)
`define JSI_US_CYC (`JSI_CLK_MHZ)
`define JSI_TRST_HOLD_MS 1
`define JSI_TRST_HOLD_US (`JSI_TRST_HOLD_MS * 1000)
`define JSI_RESET_TCKS 32'h0000_0005

// ****************************************************************
// Scan limits and TAP walk patterns, first bit in bit 0
// ****************************************************************
`define JSI_MAX_BITS 32'h0000_0100
`define JSI_IR_HDR_LEN 4'h4
`define JSI_DR_HDR_LEN 4'h3
`define JSI_IR_HDR_PAT 4'h3
`define JSI_DR_HDR_PAT 4'h1
`define JSI_NIB_W 4

// ****************************************************************
// Command codes
// ****************************************************************
`define JSI_OP_NONE 3'h0
`define JSI_OP_IR 3'h1
`define JSI_OP_DR 3'h2
`define JSI_OP_WAIT 3'h3
`define JSI_OP_TRST 3'h4
`define JSI_OP_SRST 3'h5
`define JSI_OP_CLK 3'h6
`define JSI_OP_RUN 3'h7

// ****************************************************************
// Program characters, folded to lower case
// ****************************************************************
`define JSI_CH_SEP 8'h3a
`define JSI_CH_EQ 8'h3d
`define JSI_CH_SPACE 8'h20
`define JSI_CH_0 8'h30
`define JSI_CH_9 8'h39
`define JSI_CH_A 8'h61
`define JSI_CH_F 8'h66
`define JSI_CH_I 8'h69
`define JSI_CH_D 8'h64
`define JSI_CH_W 8'h77
`define JSI_CH_T 8'h74
`define JSI_CH_R 8'h72
`define JSI_CH_C 8'h63
`define JSI_CH_H 8'h68
`define JSI_CH_L 8'h6c
`define JSI_CH_FOLD 8'h20
`define JSI_HEX_OFS 8'h57

`endif

// >>> verilog/jsi_tck_gen.v
// One TCK period with TMS and TDI set up while TCK is low
`timescale 1ns/1ps
`include "jsi_consts.vh"

module jsi_tck_gen (
	input wire clk,
	input wire reset_n,
	input wire go,
	input wire tms_in,
	input wire tdi_in,
	output reg tck_ff,
	output reg tms_ff,
	output reg tdi_ff,
	output reg done_ff
);

localparam [31:0] HALF_FULL = `JSI_TCK_HALF_CYC;
localparam [15:0] HALF = HALF_FULL[15:0];
localparam [1:0] G_IDLE = 2'h0;
localparam [1:0] G_LOW = 2'h1;
localparam [1:0] G_HIGH = 2'h2;

reg [1:0] state_ff;
reg [15:0] cnt_ff;

// ****************************************************************
// Low half then high half; target samples on the rising edge
// ****************************************************************
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		state_ff <= G_IDLE;
		cnt_ff <= 16'h0000;
		tck_ff <= 1'b0;
		tms_ff <= 1'b1;
		tdi_ff <= 1'b0;
		done_ff <= 1'b0;
	end else begin
		done_ff <= 1'b0;
		case (state_ff)
		G_IDLE: begin
			if (go) begin
				tms_ff <= tms_in;
				tdi_ff <= tdi_in;
				cnt_ff <= HALF - 16'h0001;
				state_ff <= G_LOW;
			end
		end
		G_LOW: begin
			if (cnt_ff == 16'h0000) begin
				tck_ff <= 1'b1;
				cnt_ff <= HALF - 16'h0001;
				state_ff <= G_HIGH;
			end else begin
				cnt_ff <= cnt_ff - 16'h0001;
			end
		end
		G_HIGH: begin
			if (cnt_ff == 16'h0000) begin
				tck_ff <= 1'b0;
				done_ff <= 1'b1;
				state_ff <= G_IDLE;
			end else begin
				cnt_ff <= cnt_ff - 16'h0001;
			end
		end
		default: begin
			state_ff <= G_IDLE;
		end
		endcase
	end
end

endmodule // jsi_tck_gen

// >>> dv/jsi_sequencer_chk.sv
// Port checks for the scan init sequencer
`timescale 1ns/1ps
module jsi_sequencer_chk #(
	parameter [31:0] US_CYCLES = 32'h0000_0064
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic START,
	input wire logic PROG_EN,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	input wire logic TRST_N,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic CMD_ERROR
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	logic [31:0] low_cnt_ff;
	wire start_ok = START && !BUSY && !DONE;
	// ****************
	// Test reset hold counter
	// ****************
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			low_cnt_ff <= 32'h0;
		else
			low_cnt_ff <= TRST_N ? 32'h0 : low_cnt_ff + 32'h1;
	end
	// ****************
	// Assertions
	// ****************
	busy_on_start_a: assert property (start_ok |=> BUSY)
		else $error("busy missing after start");
	done_ends_busy_a: assert property (DONE |-> !BUSY && $past(BUSY))
		else $error("done without busy run");
	done_one_cycle_a: assert property (DONE |=> !DONE)
		else $error("done longer than one cycle");
	idle_tck_low_a: assert property (!BUSY |-> !TCK)
		else $error("tck active while idle");
	tck_high_width_a: assert property ($rose(TCK) |-> TCK[*5] ##1 !TCK)
		else $error("tck high phase wrong");
	pins_steady_high_a: assert property (TCK |-> $stable(TMS) && $stable(TDI))
		else $error("tms or tdi moved with tck high");
	trst_by_cmd_a: assert property ($fell(TRST_N) |-> BUSY)
		else $error("test reset changed while idle");
	err_sticky_a: assert property (CMD_ERROR && !(START && !BUSY) |=> CMD_ERROR)
		else $error("error flag dropped early");
	trst_hold_a: assert property ($rose(TRST_N) && !PROG_EN |-> low_cnt_ff >= 32'h3e8 * US_CYCLES - 32'h1)
		else $error("test reset hold too short");
	hold_quiet_a: assert property (!PROG_EN && BUSY && !TRST_N |-> !TCK)
		else $error("tck during reset hold");
	cover property ($rose(TRST_N) && !PROG_EN);
	cover property (DONE && CMD_ERROR);
	cover property ($rose(TCK) && !TMS);
endmodule // jsi_sequencer_chk
bind jsi_sequencer jsi_sequencer_chk #(.US_CYCLES(US_CYCLES)) chk_i (.CLK(CLK),
	.RESET_N(RESET_N), .START(START), .PROG_EN(PROG_EN), .TCK(TCK),
	.TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .BUSY(BUSY), .DONE(DONE),
	.CMD_ERROR(CMD_ERROR));

// >>> dv/jsi_chain_model.sv
// Target scan chain model logging every TCK rise
`timescale 1ns/1ps
module jsi_chain_model (
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic clr
);
	// No TDO pin on the sequencer, so the chain only records what it sees
	logic tms_log [0:63];
	logic tdi_log [0:63];
	time at_log [0:63];
	int n;
	always @(posedge tck or posedge clr) begin
		if (clr) begin
			n <= 0;
		end else begin
			tms_log[n[5:0]] <= tms;
			tdi_log[n[5:0]] <= tdi;
			at_log[n[5:0]] <= $time;
			n <= n + 1;
		end
	end
endmodule // jsi_chain_model

// >>> dv/jsi_sequencer_test.sv
// Self-checking bench for the scan init sequencer
`timescale 1ns/1ps
module jsi_sequencer_test;
	logic CLK = 1'b0, RESET_N = 1'b0, START = 1'b0, PROG_EN = 1'b0;
	logic PROG_VALID = 1'b0, PROG_LAST = 1'b0, clr = 1'b0;
	logic PRED_BYPASS_EN = 1'b0, SUCC_BYPASS_EN = 1'b0;
	logic [7:0] PROG_CHAR = 8'h00;
	logic [5:0] PRED_COUNT = 6'h0, PRED_IRLEN = 6'h0;
	logic [5:0] SUCC_COUNT = 6'h0, SUCC_IRLEN = 6'h0;
	logic [31:0] PRED_BYPASS = 32'h0, SUCC_BYPASS = 32'h0;
	wire TCK, TMS, TDI, TRST_N, SYS_RESET_N, PROG_READY, BUSY, DONE, CMD_ERROR;
	logic trst_low, srst_low;
	int errors = 0, num_checks = 0;
	time t0;
	always #5 CLK = ~CLK;
	// Short microsecond keeps the 1 ms hold at 2000 cycles
	jsi_sequencer #(.US_CYCLES(32'h2)) jsi_sequencer_i (.CLK(CLK),
		.RESET_N(RESET_N), .START(START), .PROG_EN(PROG_EN),
		.PROG_CHAR(PROG_CHAR), .PROG_VALID(PROG_VALID), .PROG_LAST(PROG_LAST),
		.PRED_COUNT(PRED_COUNT), .PRED_IRLEN(PRED_IRLEN),
		.PRED_BYPASS(PRED_BYPASS), .PRED_BYPASS_EN(PRED_BYPASS_EN),
		.SUCC_COUNT(SUCC_COUNT), .SUCC_IRLEN(SUCC_IRLEN),
		.SUCC_BYPASS(SUCC_BYPASS), .SUCC_BYPASS_EN(SUCC_BYPASS_EN),
		.TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N),
		.SYS_RESET_N(SYS_RESET_N), .PROG_READY(PROG_READY), .BUSY(BUSY),
		.DONE(DONE), .CMD_ERROR(CMD_ERROR));
	jsi_chain_model jsi_chain_model_i (.tck(TCK), .tms(TMS), .tdi(TDI),
		.clr(clr));
	always @(posedge CLK) begin
		if (TRST_N === 1'b0)
			trst_low <= 1'b1;
		if (SYS_RESET_N === 1'b0)
			srst_low <= 1'b1;
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic en, input string s);
		int i;
		@(negedge CLK);
		clr = 1'b1;
		trst_low = 1'b0;
		srst_low = 1'b0;
		START = 1'b1;
		PROG_EN = en;
		@(negedge CLK);
		clr = 1'b0;
		START = 1'b0;
		t0 = $time;
		for (i = 0; i < s.len(); i++) begin
			PROG_CHAR = s[i];
			PROG_VALID = 1'b1;
			PROG_LAST = (i == s.len() - 1);
			while (PROG_READY !== 1'b1) @(negedge CLK);
			@(negedge CLK);
		end
		PROG_VALID = 1'b0;
		PROG_LAST = 1'b0;
		for (i = 0; i < 30000 && DONE !== 1'b1; i++) @(negedge CLK);
		chk(DONE, 1'b1);
		chk(BUSY, 1'b0);
	endtask
	// An x in the TDI string marks a bit that no rule fixes
	task automatic cmp_log(input string tm, input string td);
		int i;
		chk(32'(jsi_chain_model_i.n), tm.len());
		for (i = 0; i < tm.len(); i++) begin
			chk(jsi_chain_model_i.tms_log[i], tm[i] == "1");
			if (td[i] != "x")
				chk(jsi_chain_model_i.tdi_log[i], td[i] == "1");
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic test_builtin;
		run(1'b0, "");
		chk(trst_low, 1'b1);
		chk(jsi_chain_model_i.at_log[0] - t0 >= 20000, 1'b1);
		cmp_log("11111", "00000");
	endtask
	task automatic test_dr_scan;
		SUCC_COUNT = 6'h1;
		PRED_COUNT = 6'h2;
		run(1'b1, "D8=a5");
		cmp_log("1000000000000110", "xxx01010010100xx");
	endtask
	task automatic test_ir_bypass;
		SUCC_IRLEN = 6'h8;
		SUCC_BYPASS = 32'h3c;
		SUCC_BYPASS_EN = 1'b1;
		PRED_IRLEN = 6'h2;
		run(1'b1, "I4=5");
		cmp_log("11000000000000000110", "xxxx00111100101011xx");
	endtask
	task automatic test_cmd_list;
		run(1'b1, "t1:r1:ch3:w20:cl2:r0:t0");
		chk(trst_low, 1'b1);
		chk(srst_low, 1'b1);
		chk(TRST_N, 1'b1);
		chk(SYS_RESET_N, 1'b1);
		cmp_log("11100", "xxxxx");
		chk(jsi_chain_model_i.at_log[3] - jsi_chain_model_i.at_log[2] >= 400, 1'b1);
	endtask
	task automatic test_bad_cmd;
		run(1'b1, "x:d0=1:ch1");
		chk(CMD_ERROR, 1'b1);
		chk(trst_low, 1'b0);
		cmp_log("1", "x");
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(negedge CLK);
		RESET_N = 1'b1;
		test_builtin;
		test_dr_scan;
		test_ir_bypass;
		test_cmd_list;
		test_bad_cmd;
		tally_and_finish;
	end
endmodule // jsi_sequencer_test
